// ---- rtl/pmx_regs.svh ----
// Register offsets, pin masks and reset values of the port mux block
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
// ------------------------------------------------------------
// Port layout
// ------------------------------------------------------------
`define PMX_NPORT   9
`define PMX_PW      72
`define PMX_P0      0
`define PMX_P1      1
`define PMX_P8      5
`define PMX_P9      6
`define PMX_P11     8
`define PMX_NLO     5
`define PMX_NIRQ    6
`define PMX_IMPL    72'hFF0FFFFF07FFE0FFBF
`define PMX_OUTCAP  72'hFF0FFFFF07FFE0FF3E
`define PMX_DIR_RST 72'hFFFFFFFFFFFFFFFFFF
// ------------------------------------------------------------
// Register map, byte addresses
// ------------------------------------------------------------
`define PMX_OFF_LAT  12'h000
`define PMX_OFF_DIR  12'h040
`define PMX_OFF_ALT  12'h080
`define PMX_OFF_PULO 12'h0C0
`define PMX_OFF_PUHI 12'h0C4
`define PMX_OFF_LCDC 12'h0C8
`define PMX_OFF_LCDM 12'h0CC
`define PMX_OFF_EDGE 12'h0D0
`define PMX_OFF_STAT 12'h0D4
`define PMX_OFF_MASK 12'h0D8
// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define PMX_EDGE_FALL 8
`define PMX_EDGE_CSEL 16
`define PMX_LCDC_P9   4
`define PMX_ST_TIF    6
`define PMX_STW       7
`define PMX_COM_ALL   4'hF
`define PMX_COM_TWO   4'h3
`define PMX_COM_THREE 4'h7
`endif

// ---- rtl/pmx_pkg.sv ----
// Types shared by the port mux block
package pmx_pkg;
  typedef logic [71:0] pmx_pins_t;
  typedef enum logic [1:0] {
    PMX_BIAS_STATIC = 2'b00,
    PMX_BIAS_HALF   = 2'b01,
    PMX_BIAS_THIRD  = 2'b10
  } pmx_bias_t;
  typedef enum logic [1:0] {
    PMX_DIV_2 = 2'b00,
    PMX_DIV_3 = 2'b01,
    PMX_DIV_4 = 2'b10
  } pmx_div_t;
endpackage

// ---- rtl/pmx_sync.sv ----
// Two-stage pin synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
module pmx_sync #(
  parameter int W = 72
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Pins and synchronised levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] prev
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // First stage feeds only the second
  always_comb begin
    meta_d  = async_in;
    level_d = meta_q;
    prev_d  = level_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q  <= '0;
      level_q <= '0;
      prev_q  <= '0;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
      prev_q  <= prev_d;
    end
  end

  assign level = level_q;
  assign prev  = prev_q;
endmodule

// ---- rtl/pmx_top.sv ----
// Port latches, direction, pull-ups, pin mux, edge events and LCD pins
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pmx_regs.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module pmx_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pins
  input  wire pmx_pkg::pmx_pins_t pin_in,
  output pmx_pkg::pmx_pins_t     pin_out,
  output pmx_pkg::pmx_pins_t     pin_oe,
  output pmx_pkg::pmx_pins_t     pin_pu,
  // Peripheral side
  input  wire pmx_pkg::pmx_pins_t alt_out,
  input  wire pmx_pkg::pmx_pins_t alt_oe,
  output pmx_pkg::pmx_pins_t     pin_level,
  input  wire logic [7:0]        lcd_segment_outputs_low,
  input  wire logic [7:0]        lcd_segment_outputs_high,
  output logic      [3:0]        lcd_common_outputs,
  output logic      [5:0]        ext_irq_pulse,
  output logic                   wide_timer_capture_in,
  output logic                   test_input_flag,
  output logic                   irq
);
  import pmx_pkg::*;

  localparam pmx_pins_t IMPL   = `PMX_IMPL;
  localparam pmx_pins_t OUTCAP = `PMX_OUTCAP;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pmx_pins_t           lat_q, lat_d, dir_q, dir_d, alt_q, alt_d;
  pmx_pins_t           out_q, out_d, oe_q, oe_d, pu_q, pu_d;
  pmx_pins_t           lvl, prv, rd_bit;
  logic [4:0]          pulo_q, pulo_d;
  logic [3:0]          puhi_q, puhi_d;
  logic [7:0]          lcdc_q, lcdc_d;
  logic [3:0]          lcdm_q, lcdm_d;
  logic [16:0]         edge_q, edge_d;
  logic [`PMX_STW-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [5:0]          ipul_q, ipul_d;
  logic                cap_q, cap_d, irq_q, irq_d;
  logic [3:0]          com_q, com_d;
  logic [31:0]         prdata_q, prdata_d, rdata;
  logic                pready_q, pready_d, pslverr_q, pslverr_d;
  logic                hit, acc, wr;
  logic [8:0]          pu_en;
  pmx_bias_t           bias;
  pmx_div_t            divn;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  pmx_sync #(.W(`PMX_PW)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .level    (lvl),
    .prev     (prv)
  );

  // ------------------------------------------------------------
  // Per-pin mux
  // ------------------------------------------------------------
  assign pu_en = {puhi_q, pulo_q};

  genvar j;
  generate
    for (j = 0; j < `PMX_PW; j++) begin : g_pin
      localparam int K = j / 8;
      localparam int B = j % 8;
      localparam bit LCDP = (K == `PMX_P8) || (K == `PMX_P9);
      localparam bit NOALT = (K == `PMX_P0) || (K == `PMX_P1);
      logic ctl;
      logic seg;
      // Segment pins switch in pairs from the LCD control bits
      if (K == `PMX_P8) begin : g_p8
        assign ctl = lcdc_q[B/2];
        assign seg = lcd_segment_outputs_high[7-B];
      end else if (K == `PMX_P9) begin : g_p9
        assign ctl = lcdc_q[`PMX_LCDC_P9+B/2];
        assign seg = lcd_segment_outputs_low[7-B];
      end else begin : g_gen
        assign ctl = alt_q[j];
        assign seg = 1'b0;
      end
      // Port 0 and port 1 alternates are inputs only
      assign oe_d[j] = IMPL[j] & OUTCAP[j] & (ctl ? (LCDP | (~NOALT & alt_oe[j]))
                                                  : ~dir_q[j]);
      assign out_d[j] = ctl ? (LCDP ? seg : alt_out[j]) : lat_q[j];
      assign pu_d[j] = IMPL[j] & pu_en[K] & ~oe_d[j]
                       & ~((K == `PMX_P1) & ctl);
      assign rd_bit[j] = IMPL[j] & ((dir_q[j] | ~OUTCAP[j]) ? lvl[j] : lat_q[j]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Edge events
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `PMX_NIRQ; i++) begin
      ev[i] = (lvl[i] & ~prv[i] & edge_q[i])
            | (~lvl[i] & prv[i] & edge_q[`PMX_EDGE_FALL+i]);
    end
    ev[`PMX_ST_TIF] = |(prv[8*`PMX_P11 +: 8] & ~lvl[8*`PMX_P11 +: 8]);
    ipul_d = ev[5:0];
    cap_d  = edge_q[`PMX_EDGE_CSEL] ? ev[1] : ev[0];
  end

  // ------------------------------------------------------------
  // Common outputs
  // ------------------------------------------------------------
  always_comb begin
    bias  = pmx_bias_t'(lcdm_q[1:0]);
    divn  = pmx_div_t'(lcdm_q[3:2]);
    com_d = 4'h0;
    // Unlisted combinations leave the commons idle
    unique case (bias)
      PMX_BIAS_STATIC: com_d = `PMX_COM_ALL;
      PMX_BIAS_HALF:
        if (divn == PMX_DIV_2) com_d = `PMX_COM_TWO;
        else if (divn == PMX_DIV_3) com_d = `PMX_COM_THREE;
      PMX_BIAS_THIRD:
        if (divn == PMX_DIV_3) com_d = `PMX_COM_THREE;
        else if (divn == PMX_DIV_4) com_d = `PMX_COM_ALL;
      default: com_d = 4'h0;
    endcase
  end

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  assign acc = psel & ~penable;
  assign wr  = psel & penable & pready_q & pwrite;

  always_comb begin
    lat_d  = lat_q;
    dir_d  = dir_q;
    alt_d  = alt_q;
    pulo_d = pulo_q;
    puhi_d = puhi_q;
    lcdc_d = lcdc_q;
    lcdm_d = lcdm_q;
    edge_d = edge_q;
    mask_d = mask_q;
    hit    = 1'b0;
    rdata  = 32'h0;
    stat_d = stat_q;
    for (int k = 0; k < `PMX_NPORT; k++) begin
      if (paddr == `PMX_OFF_LAT + 12'(4*k)) begin
        hit   = 1'b1;
        rdata = {24'h0, rd_bit[8*k +: 8]};
        if (wr) lat_d[8*k +: 8] = pwdata[7:0] & OUTCAP[8*k +: 8];
      end
      if (paddr == `PMX_OFF_DIR + 12'(4*k)) begin
        hit   = 1'b1;
        rdata = {24'h0, dir_q[8*k +: 8] & IMPL[8*k +: 8]};
        // Pins that cannot drive stay inputs whatever is written
        if (wr) dir_d[8*k +: 8] = pwdata[7:0] | ~OUTCAP[8*k +: 8];
      end
      if (paddr == `PMX_OFF_ALT + 12'(4*k)) begin
        hit   = 1'b1;
        rdata = {24'h0, alt_q[8*k +: 8]};
        if (wr) alt_d[8*k +: 8] = pwdata[7:0] & IMPL[8*k +: 8];
      end
    end
    if (paddr == `PMX_OFF_PULO) begin
      hit   = 1'b1;
      rdata = {27'h0, pulo_q};
      if (wr) pulo_d = pwdata[4:0];
    end
    if (paddr == `PMX_OFF_PUHI) begin
      hit   = 1'b1;
      rdata = {28'h0, puhi_q};
      if (wr) puhi_d = pwdata[3:0];
    end
    if (paddr == `PMX_OFF_LCDC) begin
      hit   = 1'b1;
      rdata = {24'h0, lcdc_q};
      if (wr) lcdc_d = pwdata[7:0];
    end
    if (paddr == `PMX_OFF_LCDM) begin
      hit   = 1'b1;
      rdata = {28'h0, lcdm_q};
      if (wr) lcdm_d = pwdata[3:0];
    end
    if (paddr == `PMX_OFF_EDGE) begin
      hit   = 1'b1;
      rdata = {15'h0, edge_q};
      if (wr) edge_d = pwdata[16:0] & 17'h13F3F;
    end
    if (paddr == `PMX_OFF_MASK) begin
      hit   = 1'b1;
      rdata = {25'h0, mask_q};
      if (wr) mask_d = pwdata[`PMX_STW-1:0];
    end
    if (paddr == `PMX_OFF_STAT) begin
      hit   = 1'b1;
      rdata = {25'h0, stat_q};
      if (wr) stat_d = stat_q & ~pwdata[`PMX_STW-1:0];
    end
    // Set beats a same-cycle clear so no event is lost
    stat_d    = stat_d | ev;
    irq_d     = |(stat_q & mask_q);
    prdata_d  = acc ? rdata : prdata_q;
    pready_d  = acc;
    pslverr_d = acc & ~hit;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_q     <= '0;
      dir_q     <= `PMX_DIR_RST;
      alt_q     <= '0;
      out_q     <= '0;
      oe_q      <= '0;
      pu_q      <= '0;
      pulo_q    <= 5'h00;
      puhi_q    <= 4'h0;
      lcdc_q    <= 8'h00;
      lcdm_q    <= 4'h0;
      edge_q    <= 17'h00000;
      stat_q    <= 7'h00;
      mask_q    <= 7'h00;
      ipul_q    <= 6'h00;
      cap_q     <= 1'b0;
      irq_q     <= 1'b0;
      com_q     <= 4'h0;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      lat_q     <= lat_d;
      dir_q     <= dir_d;
      alt_q     <= alt_d;
      out_q     <= out_d;
      oe_q      <= oe_d;
      pu_q      <= pu_d;
      pulo_q    <= pulo_d;
      puhi_q    <= puhi_d;
      lcdc_q    <= lcdc_d;
      lcdm_q    <= lcdm_d;
      edge_q    <= edge_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      ipul_q    <= ipul_d;
      cap_q     <= cap_d;
      irq_q     <= irq_d;
      com_q     <= com_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign pin_out               = out_q;
  assign pin_oe                = oe_q;
  assign pin_pu                = pu_q;
  assign pin_level             = lvl;
  assign lcd_common_outputs    = com_q;
  assign ext_irq_pulse         = ipul_q;
  assign wide_timer_capture_in = cap_q;
  assign test_input_flag       = stat_q[`PMX_ST_TIF];
  assign irq                   = irq_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  input_only_a: assert property (!pin_oe[0] && !pin_oe[7])
    else $error("port 0 input-only pin driven");
  pullup_excl_a: assert property ((pin_pu & pin_oe) == '0)
    else $error("pull-up on while pin driven");
  analog_pu_off_a: assert property ((pin_pu[15:8] & $past(alt_q[15:8])) == 8'h00)
    else $error("pull-up on analog input");
  tif_set_a: assert property (|(prv[71:64] & ~lvl[71:64]) |=> test_input_flag ##1 irq || !mask_q[6])
    else $error("test input flag missed falling edge");
  rise_irq_a: assert property (lvl[0] && !prv[0] && edge_q[0] |=> ext_irq_pulse[0])
    else $error("rising edge event lost");
  no_edge_irq_a: assert property (!(lvl[2] ^ prv[2]) |=> !ext_irq_pulse[2])
    else $error("event without edge");
  capture_src_a: assert property (wide_timer_capture_in |-> ext_irq_pulse[0] || ext_irq_pulse[1])
    else $error("capture without valid edge");
  seg_pair_a: assert property ($past(lcdc_q[0]) |-> pin_oe[40] && pin_oe[41]
                               && pin_out[40] == $past(lcd_segment_outputs_high[7]))
    else $error("segment pair not driven");
  com_static_a: assert property (reset_n && lcdm_q[1:0] == 2'b00 |=> lcd_common_outputs == 4'hF)
    else $error("static mode commons wrong");
  dir_out_a: assert property ($past(!dir_q[24] && !alt_q[24]) |-> pin_oe[24]
                              && pin_out[24] == $past(lat_q[24]))
    else $error("output pin not driven from latch");
  seg_pair9_a: assert property ($past(lcdc_q[`PMX_LCDC_P9]) |-> pin_oe[48] && pin_oe[49])
    else $error("port 9 segment pair not driven");
  pu_input_only_a: assert property (pin_pu[0] == $past(pulo_q[0]))
    else $error("input-only pin pull-up not from option bit");
  dir_in_a: assert property ($past(dir_q[1] && !alt_q[1]) |-> !pin_oe[1])
    else $error("input-direction pin driven");

  tif_c: cover property (|(prv[71:64] & ~lvl[71:64]) ##1 test_input_flag);
  capture_c: cover property (wide_timer_capture_in);
  irq_c: cover property ($rose(irq));
  slverr_c: cover property (pready && pslverr);
  seg_c: cover property ($past(lcdc_q[0]) && pin_oe[40]);
endmodule

// ---- tb/pmx_pad_model.sv ----
// Pad model: resolves each pin from the block, an outside driver and pull-ups
`timescale 1ns/1ps
module pmx_pad_model (
  // Clock
  input  wire logic               clk,
  // Block side
  input  wire pmx_pkg::pmx_pins_t pin_out,
  input  wire pmx_pkg::pmx_pins_t pin_oe,
  input  wire pmx_pkg::pmx_pins_t pin_pu,
  // Outside drivers
  input  wire pmx_pkg::pmx_pins_t ext_val,
  input  wire pmx_pkg::pmx_pins_t ext_en,
  output pmx_pkg::pmx_pins_t      pin_in
);
  import pmx_pkg::*;
  // ----
  // Pad level
  // ----
  // Undriven pads wander, so a missing pull-up never reads as a steady level
  pmx_pins_t float_q = '0;
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pu | float_q));
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the port mux block
`timescale 1ns/1ps
`include "pmx_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
  import pmx_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} pmx_note_t;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        wide_timer_capture_in, test_input_flag, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ecfg;
  logic [7:0]  seg_lo, seg_hi, dv, lv, ev, om, pm;
  logic [8:0]  po;
  logic [3:0]  lcd_common_outputs;
  logic [5:0]  ext_irq_pulse;
  pmx_pins_t   pin_in, pin_out, pin_oe, pin_pu, pin_level;
  pmx_pins_t   alt_out, alt_oe, ext_val, ext_en, imp, cap;
  logic [7:0]  dvs [9];
  pmx_note_t   notes [$];
  pmx_note_t   nt;
  int          fails = 0, checks_done = 0, pcnt = 0, ccnt = 0, seed, p0, c0;

  pmx_top pmx_top_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .alt_out(alt_out), .alt_oe(alt_oe), .pin_level(pin_level),
    .lcd_segment_outputs_low(seg_lo), .lcd_segment_outputs_high(seg_hi),
    .lcd_common_outputs(lcd_common_outputs), .ext_irq_pulse(ext_irq_pulse),
    .wide_timer_capture_in(wide_timer_capture_in), .test_input_flag(test_input_flag),
    .irq(irq));
  pmx_pad_model pmx_pad_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ----
  // Clock, monitor and bus tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    pcnt <= pcnt + $countones(ext_irq_pulse);
    ccnt <= ccnt + 32'(wide_timer_capture_in === 1'b1);
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      `CHK("prdata", nt.d & nt.m, prdata & nt.m)
      `CHK("pslverr", nt.e, pslverr)
    end
  end
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    int i;
    notes.push_back('{e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    apb(1'b1, 12'(a), d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input int a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, 12'(a), 32'h0, e, m, 1'b0);
  endtask
  function automatic logic [3:0] com_exp(input int b, input int d);
    if (b == 0) return 4'hF;
    if (b == 1) return (d == 0) ? 4'h3 : (d == 1) ? 4'h7 : 4'h0;
    return (d == 1) ? 4'h7 : (d == 2) ? 4'hF : 4'h0;
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    alt_out = '0;
    alt_oe = '0;
    ext_val = '0;
    ext_en = '1;
    seg_lo = 8'h00;
    seg_hi = 8'h00;
    seed = 26;
    imp = `PMX_IMPL;
    cap = `PMX_OUTCAP;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK("oe_rst", 72'h0, pin_oe)
    `CHK("pu_rst", 72'h0, pin_pu)
    for (int k = 0; k < 9; k++) begin
      dv = 8'($random(seed));
      lv = 8'($random(seed));
      ev = 8'($random(seed));
      if (k == 3) dv[0] = 1'b0;
      dvs[k] = dv;
      ext_val[8*k +: 8] <= ev;
      wr(`PMX_OFF_DIR + 4*k, {24'h0, dv});
      wr(`PMX_OFF_LAT + 4*k, {24'h0, lv});
      repeat (2) @(posedge clk);
      om = ~dv & cap[8*k +: 8];
      `CHK("oe", om, pin_oe[8*k +: 8])
      `CHK("out", lv & om, pin_out[8*k +: 8] & om)
      rd(`PMX_OFF_LAT + 4*k, {24'h0, (lv & om) | (ev & ~om)}, {24'h0, imp[8*k +: 8]});
    end
    // Pull-up routing; port 1 analog and port 3 driven by a peripheral
    po = 9'($random(seed));
    wr(`PMX_OFF_PULO, {27'h0, po[4:0]});
    wr(`PMX_OFF_PUHI, {28'h0, po[8:5]});
    // Port 7 pin 1 as serial data out: software readies direction and latch first
    dvs[4][1] = 1'b0;
    wr(`PMX_OFF_DIR + 16, {24'h0, dvs[4]});
    wr(`PMX_OFF_LAT + 16, 32'h02);
    alt_oe[33] <= 1'b1;
    alt_out[33] <= 1'b0;
    alt_oe[31:24] <= 8'hFF;
    alt_out[31:24] <= 8'hA5;
    wr(`PMX_OFF_ALT + 16, 32'h02);
    wr(`PMX_OFF_ALT + 4, 32'hFF);
    wr(`PMX_OFF_ALT + 12, 32'hFF);
    repeat (2) @(posedge clk);
    `CHK("pu_adc", 8'h00, pin_pu[15:8])
    `CHK("alt_out", 8'hA5, pin_out[31:24])
    `CHK("alt_pu", 8'h00, pin_pu[31:24])
    `CHK("ser_out", 2'b10, {pin_oe[33], pin_out[33]})
    for (int k = 0; k < 9; k++) begin
      pm = imp[8*k +: 8];
      // Input-only pins stay inputs whatever direction was written
      ev = (dvs[k] | ~cap[8*k +: 8]) & {8{po[k] & (k != 1) & (k != 3)}};
      `CHK("pu", ev & pm, pin_pu[8*k +: 8] & pm)
    end
    // Segment pairs on ports 8 and 9
    lv = 8'($random(seed)) | 8'h11;
    seg_hi <= 8'($random(seed));
    seg_lo <= 8'($random(seed));
    wr(`PMX_OFF_LCDC, {24'h0, lv});
    repeat (2) @(posedge clk);
    for (int b = 0; b < 8; b++) begin
      if (lv[b/2]) `CHK("seg_hi", {1'b1, seg_hi[7-b]}, {pin_oe[40+b], pin_out[40+b]})
      else `CHK("p8_oe", ~dvs[5][b], pin_oe[40+b])
      if (lv[4+b/2]) `CHK("seg_lo", {1'b1, seg_lo[7-b]}, {pin_oe[48+b], pin_out[48+b]})
      else `CHK("p9_oe", ~dvs[6][b], pin_oe[48+b])
    end
    for (int b = 0; b < 3; b++) begin
      for (int d = 0; d < 3; d++) begin
        wr(`PMX_OFF_LCDM, 32'(4*d + b));
        repeat (2) @(posedge clk);
        `CHK("com", com_exp(b, d), lcd_common_outputs)
      end
    end
    // Edge selection and capture source: rising, falling, both
    wr(`PMX_OFF_DIR, 32'hFF);
    ext_val[7:0] <= 8'h00;
    for (int md = 0; md < 3; md++) begin
      ecfg = {15'h0, md[0], 2'h0, (md != 0) ? 6'h3F : 6'h00, 2'h0, (md != 1) ? 6'h3F : 6'h00};
      wr(`PMX_OFF_EDGE, ecfg);
      for (int n = 0; n < 6; n++) begin
        p0 = pcnt;
        c0 = ccnt;
        ext_val[n] <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("level", 1'b1, pin_level[n])
        ext_val[n] <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("pulses", (md == 2) ? 2 : 1, pcnt - p0)
        `CHK("capture", (n == md[0]) ? ((md == 2) ? 2 : 1) : 0, ccnt - c0)
      end
    end
    // Sticky status, mask and test input flag
    `CHK("irq_masked", 1'b0, irq)
    rd(`PMX_OFF_STAT, 32'h3F, 32'h3F);
    wr(`PMX_OFF_STAT, 32'h7F);
    rd(`PMX_OFF_STAT, 32'h0, 32'h7F);
    wr(`PMX_OFF_MASK, 32'h40);
    ext_val[71:64] <= 8'hFF;
    wr(`PMX_OFF_DIR + 32, 32'hFF);
    repeat (6) @(posedge clk);
    ext_val[71:64] <= 8'hF7;
    repeat (6) @(posedge clk);
    `CHK("tif", 1'b1, test_input_flag)
    `CHK("irq", 1'b1, irq)
    wr(`PMX_OFF_STAT, 32'h40);
    repeat (2) @(posedge clk);
    `CHK("tif_clr", 1'b0, test_input_flag)
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b0, 12'hFFC, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 12'hFFC, 32'h1, 32'h0, 32'h0, 1'b1);
    final_report();
  end
endmodule
